// file: ubg_pkg.sv
// Package for the baud generator with auto-baud and wake-up: map, fields, states, rates
package ubg_pkg;

  // ****************************************************************
  // Register map (word index on the plain register port)
  // ****************************************************************
  localparam int unsigned AW = 3;
  localparam logic [2:0] ADDR_DIV_LO  = 3'h0;
  localparam logic [2:0] ADDR_DIV_HI  = 3'h1;
  localparam logic [2:0] ADDR_CTRL    = 3'h2;
  localparam logic [2:0] ADDR_STATUS  = 3'h3;
  localparam logic [2:0] ADDR_RX_DATA = 3'h4;

  // ****************************************************************
  // Control and status register field positions
  // ****************************************************************
  localparam int unsigned BIT_AUTOBAUD_ENABLE = 0;
  localparam int unsigned BIT_WUE   = 1;
  localparam int unsigned BIT_WIDE  = 2;
  localparam int unsigned BIT_HS    = 3;
  localparam int unsigned BIT_SYNC  = 4;
  localparam int unsigned BIT_IDLE  = 6;
  localparam int unsigned BIT_OVF   = 7;
  localparam int unsigned BIT_RECEIVE_INTERRUPT_FLAG  = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] DIV_RST  = 16'h0000;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // ****************************************************************
  // Timing: prescale shifts give divide by 64, 16, 4; calibration adds 3 (x8)
  // ****************************************************************
  localparam logic [3:0] SHIFT_DIV64 = 4'h6;
  localparam logic [3:0] SHIFT_DIV16 = 4'h4;
  localparam logic [3:0] SHIFT_DIV4  = 4'h2;
  localparam logic [3:0] SHIFT_ABD   = 4'h3;
  localparam logic [2:0] ABD_RISES   = 3'h5;
  localparam logic [15:0] ABD_START  = 16'h0001;

  // Control byte as it reads back, most significant field first
  typedef struct packed {
    logic ovf;
    logic idle;
    logic rsvd;
    logic sync;
    logic hs;
    logic wide;
    logic wake_up_enable;
    logic autobaud_enable;
  } ubg_ctrl_t;

  // Calibration sequence states
  typedef enum logic [1:0] {
    AB_IDLE,
    AB_WAIT_START,
    AB_WAIT_RISE1,
    AB_COUNT
  } ubg_ab_state_t;

endpackage

// file: ubg_baud_gen.sv
// Baud timer with auto-baud calibration and wake-up on break, with plain register port
`timescale 1ns/1ps
`default_nettype none

module ubg_baud_gen
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rd_data,
  input  wire logic       rx_pin,
  input  wire logic       rx_char_done,
  input  wire logic       rx_busy,
  input  wire logic [7:0] rx_char,
  output var  logic       baud_tick,
  output var  logic       rx_hold,
  output var  logic       rx_int_flag,
  output var  logic       rx_idle
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // True on the last cycle of each 2**sh span of the prescaler
  function automatic logic presc_hit(input logic [8:0] c, input logic [3:0] sh);
    logic [8:0] mask;
    mask = (9'h001 << sh) - 9'h001;
    return (c & mask) == mask;
  endfunction

  // ****************************************************************
  // Pin synchroniser and edges
  // ****************************************************************
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  wire  rx_rise = rx_s2_r & ~rx_prev_r;
  wire  rx_fall = ~rx_s2_r & rx_prev_r;

  // Idle line is high, so all stages reset high to avoid a false edge
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_s1_r   <= rx_pin;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end

  // ****************************************************************
  // State declarations
  // ****************************************************************
  logic [15:0]            div_r;
  logic [15:0]            div_nxt;
  logic [15:0]            timer_r;
  logic [8:0]             presc_r;
  ubg_pkg::ubg_ctrl_t     ctrl_r;
  ubg_pkg::ubg_ab_state_t ab_state_r;
  ubg_pkg::ubg_ab_state_t ab_state_nxt;
  logic [2:0]             rises_r;
  logic                   wake_low_r;
  logic                   receive_interrupt_flag_r;
  logic                   tick_r;
  logic                   hold_r;
  logic                   idle_r;
  logic [7:0]             rdata_r;

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  wire wr_lo   = wr_en && addr == ubg_pkg::ADDR_DIV_LO;
  wire wr_hi   = wr_en && addr == ubg_pkg::ADDR_DIV_HI;
  wire wr_ctrl = wr_en && addr == ubg_pkg::ADDR_CTRL;
  wire rd_rx   = rd_en && addr == ubg_pkg::ADDR_RX_DATA;
  wire div_wr  = wr_lo | wr_hi;

  // ****************************************************************
  // Rate selection
  // ****************************************************************

  // Synchronous mode always divides by 4: neither wide nor high-speed select changes the shift
  wire [3:0] base_shift =
    ctrl_r.sync ? (ctrl_r.wide ? ubg_pkg::SHIFT_DIV4 : ubg_pkg::SHIFT_DIV4) :
    (ctrl_r.wide & ctrl_r.hs)  ? ubg_pkg::SHIFT_DIV4 :
    (ctrl_r.wide | ctrl_r.hs)  ? ubg_pkg::SHIFT_DIV16 : ubg_pkg::SHIFT_DIV64;
  // Calibration always uses the asynchronous table, eight times slower
  wire [3:0] abd_shift =
    ((ctrl_r.wide & ctrl_r.hs) ? ubg_pkg::SHIFT_DIV4 :
     (ctrl_r.wide | ctrl_r.hs) ? ubg_pkg::SHIFT_DIV16 : ubg_pkg::SHIFT_DIV64)
    + ubg_pkg::SHIFT_ABD;
  wire base_en = presc_hit(presc_r, base_shift);
  wire abd_en  = presc_hit(presc_r, abd_shift);

  // ****************************************************************
  // Baud timer
  // ****************************************************************
  wire        ab_busy  = ab_state_r == ubg_pkg::AB_WAIT_RISE1 ||
                         ab_state_r == ubg_pkg::AB_COUNT;
  // Narrow mode compares only the low byte; high byte is ignored
  wire [15:0] div_cmp  = ctrl_r.wide ? div_r : {8'h00, div_r[7:0]};
  wire        timer_wr = timer_r >= div_cmp;

  // Free-running prescaler shared by both rate paths
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      presc_r <= 9'h000;
    else
      presc_r <= presc_r + 9'h001;

  // Divisor write restarts the period at once; calibration parks the timer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      timer_r <= 16'h0000;
      tick_r  <= 1'b0;
    end
    else if (div_wr || ab_busy)
    begin
      timer_r <= 16'h0000;
      tick_r  <= 1'b0;
    end
    else if (base_en)
    begin
      timer_r <= timer_wr ? 16'h0000 : timer_r + 16'h0001;
      tick_r  <= timer_wr;
    end
    else
      tick_r  <= 1'b0;

  // ****************************************************************
  // Calibration sequence
  // ****************************************************************
  wire fifth_rise = ab_state_r == ubg_pkg::AB_COUNT && rx_rise &&
                    rises_r == ubg_pkg::ABD_RISES - 3'h1;
  wire cnt_step   = ab_state_r == ubg_pkg::AB_COUNT && abd_en && !fifth_rise;
  wire cnt_ovf    = cnt_step && div_r == 16'hFFFF;
  wire first_rise = ab_state_r == ubg_pkg::AB_WAIT_RISE1 && rx_rise;

  // Next state; early enable clear abandons the sequence from any state
  always_comb
  begin
    ab_state_nxt = ab_state_r;
    case (ab_state_r)
      ubg_pkg::AB_IDLE:
        if (ctrl_r.autobaud_enable && !ctrl_r.wake_up_enable)
          ab_state_nxt = ubg_pkg::AB_WAIT_START;
      ubg_pkg::AB_WAIT_START:
        if (rx_fall)
          ab_state_nxt = ubg_pkg::AB_WAIT_RISE1;
      ubg_pkg::AB_WAIT_RISE1:
        if (rx_rise)
          ab_state_nxt = ubg_pkg::AB_COUNT;
      ubg_pkg::AB_COUNT:
        if (fifth_rise)
          ab_state_nxt = ubg_pkg::AB_IDLE;
      default:
        ab_state_nxt = ubg_pkg::AB_IDLE;
    endcase
    if (!ctrl_r.autobaud_enable)
      ab_state_nxt = ubg_pkg::AB_IDLE;
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ab_state_r <= ubg_pkg::AB_IDLE;
    else
      ab_state_r <= ab_state_nxt;

  // Rising edges seen since counting began
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rises_r <= 3'h0;
    else if (first_rise)
      rises_r <= 3'h1;
    else if (ab_state_r == ubg_pkg::AB_COUNT && rx_rise)
      rises_r <= rises_r + 3'h1;

  // ****************************************************************
  // Divisor pair: software bytes, or the calibration counter
  // ****************************************************************

  // Hardware counting wins over software writes while calibrating
  always_comb
  begin
    div_nxt = div_r;
    if (first_rise)
      div_nxt = ubg_pkg::ABD_START;
    else if (cnt_step)
      div_nxt = div_r + 16'h0001;
    else if (!ab_busy && wr_lo)
      div_nxt = {div_r[15:8], wr_data};
    else if (!ab_busy && wr_hi)
      div_nxt = {wr_data, div_r[7:0]};
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      div_r <= ubg_pkg::DIV_RST;
    else
      div_r <= div_nxt;

  // ****************************************************************
  // Control bits, wake-up watch
  // ****************************************************************
  wire wake_on   = ctrl_r.wake_up_enable && !ctrl_r.sync;
  wire wake_evt  = wake_on && !wake_low_r && rx_fall;
  wire break_end = wake_on && wake_low_r && rx_rise;

  // Hardware clears override a software write in the same cycle
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ctrl_r <= ubg_pkg::ubg_ctrl_t'(ubg_pkg::CTRL_RST);
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_r.autobaud_enable <= wr_data[ubg_pkg::BIT_AUTOBAUD_ENABLE];
        ctrl_r.wake_up_enable   <= wr_data[ubg_pkg::BIT_WUE];
        ctrl_r.wide  <= wr_data[ubg_pkg::BIT_WIDE];
        ctrl_r.hs    <= wr_data[ubg_pkg::BIT_HS];
        ctrl_r.sync  <= wr_data[ubg_pkg::BIT_SYNC];
        if (!wr_data[ubg_pkg::BIT_OVF])
          ctrl_r.ovf <= 1'b0;
      end
      if (fifth_rise)
        ctrl_r.autobaud_enable <= 1'b0;
      if (cnt_ovf)
        ctrl_r.ovf <= 1'b1;
      if (break_end)
        ctrl_r.wake_up_enable <= 1'b0;
      ctrl_r.idle <= 1'b0;
      ctrl_r.rsvd <= 1'b0;
    end

  // Low phase of the break; dropped if software gives up the wake-up
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      wake_low_r <= 1'b0;
    else if (!wake_on || break_end)
      wake_low_r <= 1'b0;
    else if (wake_evt)
      wake_low_r <= 1'b1;

  // ****************************************************************
  // Receive flag, hold and idle
  // ****************************************************************
  wire receive_interrupt_flag_set = fifth_rise | cnt_ovf | wake_evt |
                  (rx_char_done && !hold_r);

  // A set in the same cycle as the clearing read wins
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      receive_interrupt_flag_r <= 1'b0;
    else if (receive_interrupt_flag_set)
      receive_interrupt_flag_r <= 1'b1;
    else if (rd_rx)
      receive_interrupt_flag_r <= 1'b0;

  // Receiver held while calibrating or watching for a break
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      hold_r <= 1'b0;
      idle_r <= 1'b1;
    end
    else
    begin
      hold_r <= ctrl_r.autobaud_enable | wake_on;
      idle_r <= !rx_busy && !ab_busy;
    end

  // ****************************************************************
  // Read data, valid in the cycle after the strobe
  // ****************************************************************
  ubg_pkg::ubg_ctrl_t ctrl_view;
  always_comb
  begin
    ctrl_view      = ctrl_r;
    ctrl_view.idle = idle_r;
  end

  wire [7:0] rd_mux =
    addr == ubg_pkg::ADDR_DIV_LO  ? div_r[7:0] :
    addr == ubg_pkg::ADDR_DIV_HI  ? div_r[15:8] :
    addr == ubg_pkg::ADDR_CTRL    ? ctrl_view :
    addr == ubg_pkg::ADDR_STATUS  ? {7'h00, receive_interrupt_flag_r} :
    addr == ubg_pkg::ADDR_RX_DATA ? rx_char : 8'h00;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_en ? rd_mux : 8'h00;

  assign rd_data     = rdata_r;
  assign baud_tick   = tick_r;
  assign rx_hold     = hold_r;
  assign rx_int_flag = receive_interrupt_flag_r;
  assign rx_idle     = idle_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_counting;
    ab_state_r == ubg_pkg::AB_COUNT;
  endsequence
  sequence s_fifth;
    s_counting ##0 fifth_rise;
  endsequence

  narrow_timer_a: assert property (!ctrl_r.wide && !div_wr && !ab_busy && timer_r <= div_cmp
    |=> timer_r[15:8] == 8'h00)
    else $error("narrow timer grew past low byte");
  tick_period_a: assert property (tick_r |-> $past(timer_r) >= $past(div_cmp))
    else $error("tick without reaching divisor");
  div_clear_a: assert property (div_wr |=> timer_r == 16'h0000)
    else $error("divisor write did not clear timer");
  abd_hold_a: assert property (ab_state_r != ubg_pkg::AB_IDLE |-> hold_r)
    else $error("receiver not held during calibration");
  abd_start_a: assert property (first_rise |=> s_counting ##0 div_r == 16'h0001)
    else $error("calibration did not start at one");
  abd_done_a: assert property (s_fifth |=> !ctrl_r.autobaud_enable && receive_interrupt_flag_r
    && ab_state_r == ubg_pkg::AB_IDLE)
    else $error("fifth rise did not finish calibration");
  abd_rate_a: assert property (s_counting ##0 !abd_en ##0 !first_rise
    |=> $stable(div_r))
    else $error("calibration counter moved off its rate");
  abd_ovf_a: assert property (cnt_ovf |=> ctrl_r.ovf && receive_interrupt_flag_r && div_r == 16'h0000)
    else $error("overflow not flagged");
  idle_low_a: assert property (s_counting ##1 s_counting |-> !idle_r)
    else $error("idle status high while calibrating");
  rx_read_clr_a: assert property (rd_rx && !receive_interrupt_flag_set |=> !receive_interrupt_flag_r)
    else $error("data read did not clear flag");
  wake_set_a: assert property (wake_evt |=> receive_interrupt_flag_r && wake_low_r)
    else $error("wake event did not set flag");
  wue_clear_a: assert property (break_end |=> !ctrl_r.wake_up_enable ##1 !hold_r || ctrl_r.autobaud_enable)
    else $error("break end did not clear wake-up");

endmodule

`default_nettype wire

// file: ubg_remote_tx.sv
// Remote asynchronous transmitter model that drives the receive pin
`timescale 1ns/1ps
`default_nettype none

module ubg_remote_tx
(
  input  wire logic clk,
  output var  logic rx_pin
);
  // Line idles high as if pulled up; level changes just after a clock edge
  initial rx_pin = 1'b1;

  // One bit time at a given level
  task automatic hold_bit(input logic lvl, input int bit_clks);
  begin
    @(posedge clk);
    rx_pin <= lvl;
    repeat (bit_clks - 1) @(posedge clk);
  end
  endtask

  // Start bit, eight data bits lsb first, stop bit
  task automatic send_byte(input logic [7:0] b, input int bit_clks);
  begin
    hold_bit(1'b0, bit_clks);
    for (int i = 0; i < 8; i++) hold_bit(b[i], bit_clks);
    hold_bit(1'b1, bit_clks);
  end
  endtask

  // All-zero wake character; callers keep it ten bits or longer
  task automatic send_break(input int nbits, input int bit_clks);
  begin
    for (int i = 0; i < nbits; i++) hold_bit(1'b0, bit_clks);
    hold_bit(1'b1, bit_clks);
  end
  endtask
endmodule

`default_nettype wire

// file: test_ubg_baud_gen.sv
// Self-checking testbench for the baud generator with auto-baud and wake-up
`timescale 1ns/1ps
`default_nettype none

module test_ubg_baud_gen;
  localparam int BIT = 320;
  // Calibration at clk/32: eight bit times plus the starting count of one
  localparam int CAL = 8 * BIT / 32 + 1;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rd_data;
  logic       rx_pin;
  logic       rx_char_done = 1'b0;
  logic       rx_busy = 1'b0;
  logic [7:0] rx_char = 8'hA5;
  logic       baud_tick;
  logic       rx_hold;
  logic       rx_int_flag;
  logic       rx_idle;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] v;
  logic [15:0] n;

  // ****************************************************************
  // Design, far-side transmitter, clock and watchdog
  // ****************************************************************
  ubg_baud_gen dut (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin), .rx_char_done(rx_char_done),
    .rx_busy(rx_busy), .rx_char(rx_char), .baud_tick(baud_tick), .rx_hold(rx_hold),
    .rx_int_flag(rx_int_flag), .rx_idle(rx_idle));
  ubg_remote_tx tx (.clk(clk), .rx_pin(rx_pin));

  always #4 clk = ~clk;

  // Hang guard, well above the roughly 27500 cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
  begin
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  end
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  end
  endtask

  task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
  begin
    rd(a, d);
    chk(nm, {8'h00, exp}, {8'h00, d});
  end
  endtask

  // Cycles between two consecutive ticks; the first gap may be short
  task automatic tick_gap(output logic [15:0] g);
    int k;
  begin
    k = 0;
    while (baud_tick !== 1'b1 && k < 20000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    g = 16'h0000;
    do
    begin
      @(posedge clk);
      #1;
      g++;
    end while (baud_tick !== 1'b1 && g < 16'h4E20);
  end
  endtask

  // Sync character, optionally after a wake-up break, with checks alongside
  task automatic cal_run(input logic [7:0] c, input logic brk);
  begin
    wr(ubg_pkg::ADDR_CTRL, c);
    repeat (4) @(posedge clk);
    fork
      begin
        if (brk) tx.send_break(13, BIT);
        if (brk) repeat (2 * BIT) @(posedge clk);
        tx.send_byte(8'h55, BIT);
      end
      begin
        if (brk)
        begin
          @(negedge rx_pin);
          repeat (6) @(posedge clk);
          #1;
          chk("wake_flag", 16'h1, {15'h0, rx_int_flag});
          chk("wake_hold", 16'h1, {15'h0, rx_hold});
          @(posedge rx_pin);
          repeat (6) @(posedge clk);
          rd_chk("ctrl_wake_end", ubg_pkg::ADDR_CTRL, 8'h4D);
          rd(ubg_pkg::ADDR_RX_DATA, v);
          rd_chk("status_wake_clr", ubg_pkg::ADDR_STATUS, 8'h00);
        end
        else
        begin
          repeat (3 * BIT) @(posedge clk);
          #1;
          chk("cal_hold", 16'h1, {15'h0, rx_hold});
          chk("cal_idle", 16'h0, {15'h0, rx_idle});
        end
      end
    join
    repeat (8) @(posedge clk);
    #1;
    chk("cal_flag", 16'h1, {15'h0, rx_int_flag});
    rd_chk("ctrl_cal_end", ubg_pkg::ADDR_CTRL, 8'h4C);
    rd(ubg_pkg::ADDR_DIV_LO, v);
    n[7:0] = v;
    rd(ubg_pkg::ADDR_DIV_HI, v);
    n[15:8] = v;
    chk("cal_count", 16'h1, {15'h0, n >= CAL - 1 && n <= CAL + 1});
    rd(ubg_pkg::ADDR_RX_DATA, v);
    rd_chk("status_cal_clr", ubg_pkg::ADDR_STATUS, 8'h00);
    // Overflow clear once the receiver reads idle
    wr(ubg_pkg::ADDR_CTRL, 8'h0C);
    rd_chk("ctrl_ovf_clr", ubg_pkg::ADDR_CTRL, 8'h4C);
  end
  endtask

  task automatic final_report();
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // Mode table: control, expected tick gap; divisor high 01 and low 02 for every mode
  logic [7:0]  t_ctrl [7] = '{8'h00, 8'h08, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h14};
  logic [15:0] t_gap  [7] = '{16'd192, 16'd48, 16'd4144, 16'd1036, 16'd12, 16'd12, 16'd1036};

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("ctrl_reset", ubg_pkg::ADDR_CTRL, 8'h40);
    rd_chk("div_lo_reset", ubg_pkg::ADDR_DIV_LO, 8'h00);
    rd_chk("div_hi_reset", ubg_pkg::ADDR_DIV_HI, 8'h00);
    rd_chk("unmapped", 3'h5, 8'h00);
    // Narrow modes ignore the high byte, wide modes use both
    for (int i = 0; i < 7; i++)
    begin
      wr(ubg_pkg::ADDR_CTRL, t_ctrl[i]);
      wr(ubg_pkg::ADDR_DIV_HI, 8'h01);
      wr(ubg_pkg::ADDR_DIV_LO, 8'h02);
      tick_gap(n);
      chk("tick_gap", t_gap[i], n);
    end
    // Divisor write mid-period must not wait for the old period
    wr(ubg_pkg::ADDR_CTRL, 8'h0C);
    wr(ubg_pkg::ADDR_DIV_HI, 8'h00);
    wr(ubg_pkg::ADDR_DIV_LO, 8'hFF);
    tick_gap(n);
    repeat (800) @(posedge clk);
    wr(ubg_pkg::ADDR_DIV_LO, 8'h02);
    for (n = 16'h0; n < 16'h0100 && baud_tick !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("tick_after_write", 16'h1, {15'h0, n >= 16'd6 && n <= 16'd14});
    // Character from the receiver sets and a data read clears the flag
    @(posedge clk);
    rx_busy <= 1'b1;
    wr(ubg_pkg::ADDR_CTRL, 8'h00);
    rd_chk("ctrl_busy", ubg_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk);
    rx_busy <= 1'b0;
    rx_char_done <= 1'b1;
    @(posedge clk);
    rx_char_done <= 1'b0;
    rd_chk("status_char", ubg_pkg::ADDR_STATUS, 8'h01);
    rd_chk("rx_data", ubg_pkg::ADDR_RX_DATA, 8'hA5);
    rd_chk("status_clr", ubg_pkg::ADDR_STATUS, 8'h00);
    // Early clear of auto-baud releases the receiver
    wr(ubg_pkg::ADDR_CTRL, 8'h01);
    @(posedge clk);
    #1;
    chk("abort_held", 16'h1, {15'h0, rx_hold});
    wr(ubg_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("abort_hold", 16'h0, {15'h0, rx_hold});
    cal_run(8'h0D, 1'b0);
    cal_run(8'h0F, 1'b1);
    final_report();
  end
endmodule

`default_nettype wire
